// File: hdl/omr_consts.vh
// constants for the operating-mode control register block
`ifndef OMR_CONSTS_VH
`define OMR_CONSTS_VH
`define OMR_ADDR_OFFSET   12'h02C
`define OMR_INDEX         8'h0B
`define OMR_MODE_HI       7
`define OMR_MODE_LO       5
`define OMR_VIS_BIT       3
`define OMR_EMK_BIT       1
`define OMR_EME_BIT       0
`define OMR_M_SSC         3'h0
`define OMR_M_EMN         3'h1
`define OMR_M_STEST       3'h2
`define OMR_M_EMW         3'h3
`define OMR_M_NSC         3'h4
`define OMR_M_NXN         3'h5
`define OMR_M_SPER        3'h6
`define OMR_M_NXW         3'h7
`define OMR_RESP_OKAY     2'h0
`define OMR_RESP_SLVERR   2'h2
`endif

// File: hdl/omr_write_gate.v
// per-bit write permission for the operating-mode control register
`include "omr_consts.vh"
module omr_write_gate (
    // current state
    input  wire [2:0] mode_field,
    input  wire       secure_mode,
    input  wire       mode_once_left,
    input  wire       vis_once_left,
    input  wire       emk_once_left,
    // requested values
    input  wire [2:0] wr_mode,
    // permissions
    output reg        mode_hi_ok,
    output reg        mode_lo_ok,
    output reg        vis_ok,
    output reg        emk_ok,
    output reg        eme_ok
);
    wire special = (mode_field == `OMR_M_SSC) || (mode_field == `OMR_M_STEST);
    wire emul    = (mode_field == `OMR_M_EMN) || (mode_field == `OMR_M_EMW);
    wire normal  = !special && !emul && (mode_field != `OMR_M_SPER);
    always @* begin
        mode_hi_ok = 1'b0;
        mode_lo_ok = 1'b0;
        if (secure_mode) begin
            mode_hi_ok = 1'b0;
        end else if (mode_field[0]) begin
            mode_hi_ok = 1'b0;
        end else if (special) begin
            mode_hi_ok = (wr_mode != `OMR_M_SPER);
            mode_lo_ok = mode_hi_ok;
        end else if (mode_field == `OMR_M_NSC) begin
            mode_lo_ok = mode_once_left && wr_mode[0];
        end
        vis_ok = special || (normal && vis_once_left);
        emk_ok = special || (normal && emk_once_left);
        eme_ok = special;
    end
endmodule

// File: hdl/omr_regs.v
// operating-mode control register with axi4-lite slave and map decode
//
// The AXI4-Lite interface to the registers was decided locally.
`include "omr_consts.vh"
module omr_regs #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input  wire              mclk,
    input  wire              rst,
    // mode straps and security
    input  wire [2:0]        reset_mode,
    input  wire              secure_mode,
    // axi4-lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // axi4-lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // configuration outputs
    output wire [2:0]        mode_field,
    output wire              internal_visibility_en,
    output wire              port_k_emulation_en,
    output wire              port_e_emulation_en,
    output reg               port_k_mapped,
    output reg               port_e_mapped,
    output reg               mode_reg_mapped,
    output wire              ext_echo_access,
    output reg               ext_visible_access
);
    reg [2:0]  mode_reg;
    reg        vis_reg;
    reg        emk_reg;
    reg        eme_reg;
    reg        mode_once_reg;
    reg        vis_once_reg;
    reg        emk_once_reg;
    reg        strap_pend_reg;
    reg        aw_hold_reg;
    reg        w_hold_reg;
    reg [ADDR_W-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;
    reg        echo_reg;
    reg [2:0]  strap_meta_reg;
    reg [2:0]  strap_sync_reg;

    localparam [ADDR_W-1:0] REG_BYTE_ADDR = `OMR_ADDR_OFFSET;

    // mode straps come from pins: two flops before the strap capture reads them
    always @(posedge mclk) begin
        strap_meta_reg <= reset_mode;
        strap_sync_reg <= strap_meta_reg;
    end

    assign mode_field             = mode_reg;
    assign internal_visibility_en = vis_reg;
    assign port_k_emulation_en    = emk_reg;
    assign port_e_emulation_en    = eme_reg;
    assign ext_echo_access        = echo_reg;

    function is_expanded;
        input [2:0] m;
        begin
            is_expanded = m[0];
        end
    endfunction
    function is_emul;
        input [2:0] m;
        begin
            is_emul = (m == `OMR_M_EMN) || (m == `OMR_M_EMW);
        end
    endfunction
    function is_special;
        input [2:0] m;
        begin
            is_special = (m == `OMR_M_SSC) || (m == `OMR_M_STEST);
        end
    endfunction

    // map decode
    always @* begin
        mode_reg_mapped = !is_expanded(mode_reg) && (mode_reg != `OMR_M_SPER);
        if (mode_reg == `OMR_M_SPER)
            port_k_mapped = 1'b0;
        else if (is_expanded(mode_reg))
            port_k_mapped = !emk_reg;
        else
            port_k_mapped = 1'b1;
        if (is_expanded(mode_reg) || (mode_reg == `OMR_M_SPER))
            port_e_mapped = !eme_reg;
        else
            port_e_mapped = 1'b1;
    end

    wire [2:0] wr_mode = w_data_reg[`OMR_MODE_HI:`OMR_MODE_LO];
    wire mode_hi_ok;
    wire mode_lo_ok;
    wire vis_ok;
    wire emk_ok;
    wire eme_ok;

    omr_write_gate u_gate (
        .mode_field     (mode_reg),
        .secure_mode    (secure_mode),
        .mode_once_left (mode_once_reg),
        .vis_once_left  (vis_once_reg),
        .emk_once_left  (emk_once_reg),
        .wr_mode        (wr_mode),
        .mode_hi_ok     (mode_hi_ok),
        .mode_lo_ok     (mode_lo_ok),
        .vis_ok         (vis_ok),
        .emk_ok         (emk_ok),
        .eme_ok         (eme_ok)
    );

    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    wire wr_go   = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    wire wr_hit  = (aw_addr_reg[ADDR_W-1:2] == REG_BYTE_ADDR[ADDR_W-1:2]);
    wire wr_here = wr_go && wr_hit && mode_reg_mapped && w_strb_reg[0];

    always @(posedge mclk) begin
        if (rst) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            aw_addr_reg  <= {ADDR_W{1'b0}};
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `OMR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_hit && mode_reg_mapped) ? `OMR_RESP_OKAY : `OMR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register contents; strap captured on the first clock after reset release
    always @(posedge mclk) begin
        if (rst) begin
            mode_reg       <= `OMR_M_SSC;
            vis_reg        <= 1'b0;
            emk_reg        <= 1'b0;
            eme_reg        <= 1'b0;
            mode_once_reg  <= 1'b0;
            vis_once_reg   <= 1'b0;
            emk_once_reg   <= 1'b0;
            strap_pend_reg <= 1'b1;
        end else if (strap_pend_reg) begin
            strap_pend_reg <= 1'b0;
            mode_reg       <= strap_sync_reg;
            vis_reg        <= is_emul(strap_sync_reg) || (strap_sync_reg == `OMR_M_STEST);
            emk_reg        <= is_emul(strap_sync_reg);
            eme_reg        <= is_emul(strap_sync_reg);
            mode_once_reg  <= (strap_sync_reg == `OMR_M_NSC);
            vis_once_reg   <= 1'b1;
            emk_once_reg   <= 1'b1;
        end else if (wr_here) begin
            // values take effect at the edge after the write cycle
            if (mode_hi_ok)
                mode_reg[2] <= wr_mode[2];
            if (mode_lo_ok) begin
                mode_reg[1:0] <= wr_mode[1:0];
                if (!mode_hi_ok)
                    mode_once_reg <= 1'b0;
            end
            if (mode_hi_ok && mode_lo_ok)
                mode_once_reg <= (wr_mode == `OMR_M_NSC);
            if (vis_ok) begin
                vis_reg <= w_data_reg[`OMR_VIS_BIT];
                if (!is_special(mode_reg))
                    vis_once_reg <= 1'b0;
            end
            if (emk_ok) begin
                emk_reg <= w_data_reg[`OMR_EMK_BIT];
                if (!is_special(mode_reg))
                    emk_once_reg <= 1'b0;
            end
            if (eme_ok)
                eme_reg <= w_data_reg[`OMR_EME_BIT];
        end
    end

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    wire rd_hit = (s_axi_araddr[ADDR_W-1:2] == REG_BYTE_ADDR[ADDR_W-1:2]);
    always @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `OMR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (rd_hit && mode_reg_mapped) begin
                s_axi_rresp <= `OMR_RESP_OKAY;
                s_axi_rdata <= {24'h00_0000, mode_reg, 1'b0, vis_reg, 1'b0, emk_reg, eme_reg};
            end else begin
                s_axi_rresp <= `OMR_RESP_SLVERR;
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // external bus cycle indications
    always @(posedge mclk) begin
        if (rst) begin
            echo_reg           <= 1'b0;
            ext_visible_access <= 1'b0;
        end else begin
            echo_reg <= (wr_go && wr_hit && !mode_reg_mapped) ||
                        (s_axi_arvalid && s_axi_arready && rd_hit && !mode_reg_mapped);
            ext_visible_access <= vis_reg && (wr_go || (s_axi_arvalid && s_axi_arready));
        end
    end
endmodule

// File: verif/omr_assertions.sv
// port checker for the operating-mode control register
module omr_assertions (
    input logic        mclk,
    input logic        rst,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic [2:0]  mode_field,
    input logic        internal_visibility_en,
    input logic        port_k_emulation_en,
    input logic        port_e_emulation_en,
    input logic        port_k_mapped,
    input logic        port_e_mapped,
    input logic        mode_reg_mapped,
    input logic        ext_echo_access,
    input logic        ext_visible_access
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    // modes with the low mode bit clear, other than peripheral, keep both ports mapped
    wire sc = !mode_field[0] && (mode_field != 3'h6);
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_unused_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0 && !s_axi_rdata[4] && !s_axi_rdata[2])
        else $error("unused bits set");
    a_unmapped_err: assert property (ar_take && !mode_reg_mapped |=> s_axi_rresp == 2'h2 && ext_echo_access)
        else $error("unmapped read not echoed");
    a_visible_pulse: assert property (ar_take && internal_visibility_en |=> ext_visible_access)
        else $error("visible access missing");
    a_reg_map: assert property (mode_reg_mapped == !(mode_field[0] || mode_field == 3'h6))
        else $error("register map wrong");
    a_port_k_data_reg_map: assert property (port_k_mapped == (sc || (mode_field != 3'h6 && !port_k_emulation_en)))
        else $error("port k map wrong");
    a_port_e_data_reg_map: assert property (port_e_mapped == (sc || !port_e_emulation_en))
        else $error("port e map wrong");
    a_mode_lock: assert property (!$past(rst) && $past(mode_field[0]) |-> $stable(mode_field))
        else $error("locked mode changed");
    c_echo: cover property (ext_echo_access);
    c_visible: cover property (ext_visible_access);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind omr_regs omr_assertions omr_assertions_i (.*);

// File: verif/omr_core_model.sv
// axi4-lite master standing in for the processor core
`include "omr_consts.vh"
module omr_core_model (
    input  logic        mclk,
    output logic [11:0] s_axi_awaddr,
    output logic        s_axi_awvalid,
    input  logic        s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0]  s_axi_wstrb,
    output logic        s_axi_wvalid,
    input  logic        s_axi_wready,
    input  logic [1:0]  s_axi_bresp,
    input  logic        s_axi_bvalid,
    output logic        s_axi_bready,
    output logic [11:0] s_axi_araddr,
    output logic        s_axi_arvalid,
    input  logic        s_axi_arready,
    input  logic [31:0] s_axi_rdata,
    input  logic [1:0]  s_axi_rresp,
    input  logic        s_axi_rvalid,
    output logic        s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 28'h000_0000;
        s_axi_wdata = 32'h0000_0000;
    end
    // address and data offered together, each dropped when taken
    task wr(input logic [7:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_awaddr <= `OMR_ADDR_OFFSET;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge mclk);
        d = s_axi_rdata[7:0];
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench for the operating-mode control register
`include "omr_consts.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reset_mode = 3'h0;
    logic        secure_mode = 1'b0;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [2:0]  mode_field;
    logic        internal_visibility_en, port_k_emulation_en, port_e_emulation_en, port_k_mapped;
    logic        port_e_mapped, mode_reg_mapped, ext_echo_access, ext_visible_access, v, k;
    logic [7:0]  d;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    omr_regs omr_regs_i (.*);
    omr_core_model omr_core_model_i (.*);
    always #50 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 8000) begin
            miscompares++;
            end_sim();
        end
    end
    task end_sim();
        if (miscompares == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task do_reset(input logic [2:0] m);
        @(posedge mclk);
        rst <= 1'b1;
        reset_mode <= m;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    // compares the mode, enable and map output levels, then reads the register back
    task chk(input logic [2:0] m, input logic vi, ki, ei);
        logic sc;
        sc = !m[0] && (m != 3'h6);
        @(negedge mclk);
        `CHK("mode", m, mode_field)
        `CHK("vis", vi, internal_visibility_en)
        `CHK("emk", ki, port_k_emulation_en)
        `CHK("eme", ei, port_e_emulation_en)
        `CHK("kmap", sc || (m != 3'h6 && !ki), port_k_mapped)
        `CHK("emap", sc || !ei, port_e_mapped)
        `CHK("rmap", !(m[0] || m == 3'h6), mode_reg_mapped)
        omr_core_model_i.rd(`OMR_ADDR_OFFSET, d, r);
        if (m[0] || m == 3'h6)
            `CHK("rresp", `OMR_RESP_SLVERR, r)
        else
            `CHK("rdata", {m, 1'b0, vi, 1'b0, ki, ei}, d)
    endtask
    task w(input logic [7:0] wd, input logic [1:0] er);
        omr_core_model_i.wr(wd, r);
        `CHK("bresp", er, r)
    endtask
    initial begin
        for (int i = 0; i < 8; i++) begin
            v = (i >= 1) && (i <= 3);
            k = (i == 1) || (i == 3);
            do_reset(i[2:0]);
            chk(i[2:0], v, k, k);
            if (i[0] || i == 6) begin
                w(8'h00, `OMR_RESP_SLVERR);
                chk(i[2:0], v, k, k);
            end
        end
        do_reset(3'h0);
        omr_core_model_i.rd(12'h030, d, r);
        `CHK("bad addr", `OMR_RESP_SLVERR, r)
        w(8'h5B, `OMR_RESP_OKAY);
        chk(3'h2, 1'b1, 1'b1, 1'b1);
        w(8'hCB, `OMR_RESP_OKAY);
        chk(3'h2, 1'b1, 1'b1, 1'b1);
        secure_mode <= 1'b1;
        w(8'h0B, `OMR_RESP_OKAY);
        chk(3'h2, 1'b1, 1'b1, 1'b1);
        secure_mode <= 1'b0;
        w(8'h80, `OMR_RESP_OKAY);
        chk(3'h4, 1'b0, 1'b0, 1'b0);
        w(8'h8B, `OMR_RESP_OKAY);
        chk(3'h4, 1'b1, 1'b1, 1'b0);
        w(8'h80, `OMR_RESP_OKAY);
        chk(3'h4, 1'b1, 1'b1, 1'b0);
        w(8'h20, `OMR_RESP_OKAY);
        chk(3'h5, 1'b1, 1'b1, 1'b0);
        end_sim();
    end
endmodule
